/* File: design/aalo_alu.sv */
// combinational add and bitwise-and unit with flag generation
`timescale 1ns/1ns
module aalo_alu
  import aalo_pkg::*;
(
  input  wire aalo_op_e           op_in,
  input  wire logic [DATA_W-1:0]  acc_in,
  input  wire logic [DATA_W-1:0]  mem_in,
  input  wire logic [DATA_W-1:0]  imm_in,
  input  wire aalo_flags_s        flags_in,
  output aalo_flags_s             flags_out,
  output logic [DATA_W-1:0]       result_out,
  output logic                    to_memory_out
);

  logic [DATA_W:0]   sum9;
  logic [4:0]        low5;
  logic              carry_into_msb;
  logic              ov;

  // adder with nibble and sign-bit carries
  always_comb begin
    sum9           = {1'b0, acc_in} + {1'b0, mem_in};
    low5           = {1'b0, acc_in[3:0]} + {1'b0, mem_in[3:0]};
    carry_into_msb = acc_in[7] ^ mem_in[7] ^ sum9[7];
    ov             = carry_into_msb ^ sum9[DATA_W];
  end

  // result select and flag update per instruction
  always_comb begin
    flags_out     = flags_in;
    result_out    = acc_in & mem_in;
    to_memory_out = 1'b0;
    case (op_in)
      OP_ADD_ACC_INTO_MEMORY: begin
        result_out                    = sum9[DATA_W-1:0];
        to_memory_out                 = 1'b1;
        flags_out.carry_flag          = sum9[DATA_W];
        flags_out.aux_carry_flag      = low5[4];
        flags_out.overflow_flag       = ov;
        flags_out.signed_compare_flag = ov ^ sum9[7];
        flags_out.zero_flag           = aalo_is_zero(sum9[DATA_W-1:0]);
      end
      OP_AND_MEM_INTO_ACC: begin
        result_out          = acc_in & mem_in;
        flags_out.zero_flag = aalo_is_zero(acc_in & mem_in);
      end
      OP_AND_IMM_INTO_ACC: begin
        result_out          = acc_in & imm_in;
        flags_out.zero_flag = aalo_is_zero(acc_in & imm_in);
      end
      OP_BITWISE_CONJ_ACC_INTO_MEM: begin
        result_out          = acc_in & mem_in;
        to_memory_out       = 1'b1;
        flags_out.zero_flag = aalo_is_zero(acc_in & mem_in);
      end
      default: begin
        result_out = acc_in;
      end
    endcase
  end

endmodule : aalo_alu

/* File: design/aalo_datapath.sv */
// accumulator datapath: data memory, accumulator, flags and AXI4-Lite register slave
//
// Behaviour
// - add-to-memory sums accumulator and addressed byte and updates overflow, zero, aux carry, carry, signed compare.
// - add-to-memory writes the sum back to the addressed byte and leaves the accumulator alone.
// - the memory-operand and forms accumulator and addressed byte and changes only the zero flag.
// - both and forms that target the accumulator write it and leave data memory untouched.
// - the immediate and forms accumulator and instruction constant and changes only the zero flag.
// - and-to-memory forms accumulator and addressed byte and writes it to the addressed byte.
`timescale 1ns/1ns
module aalo_datapath
  import aalo_pkg::*;
#(
  parameter int MEM_DEPTH = 256
)(
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  // decoder side
  input  wire aalo_instr_s        instr_in,
  output logic                    done_out,
  output logic [DATA_W-1:0]       result_out,
  output logic [DATA_W-1:0]       acc_out,
  output aalo_flags_s             flags_out,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0]  s_axi_awaddr_in,
  input  wire logic               s_axi_awvalid_in,
  output logic                    s_axi_awready_out,
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  input  wire logic               s_axi_wvalid_in,
  output logic                    s_axi_wready_out,
  output logic [1:0]              s_axi_bresp_out,
  output logic                    s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  input  wire logic [AXI_AW-1:0]  s_axi_araddr_in,
  input  wire logic               s_axi_arvalid_in,
  output logic                    s_axi_arready_out,
  output logic [31:0]             s_axi_rdata_out,
  output logic [1:0]              s_axi_rresp_out,
  output logic                    s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_RESP = 2'h2
  } aalo_bus_e;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [DATA_W-1:0]  data_mem [MEM_DEPTH];
  logic [DATA_W-1:0]  accumulator_reg;
  logic [DATA_W-1:0]  accumulator_next;
  aalo_flags_s        flags_reg;
  aalo_flags_s        flags_next;
  logic [MEM_AW-1:0]  mem_addr_reg;
  logic [MEM_AW-1:0]  mem_addr_next;
  logic               done_reg;
  logic               done_next;
  logic [DATA_W-1:0]  result_reg;
  logic [DATA_W-1:0]  result_next;
  logic               mem_we;
  logic [MEM_AW-1:0]  mem_wa;
  logic [DATA_W-1:0]  mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  // alu

  aalo_flags_s        alu_flags;
  logic [DATA_W-1:0]  alu_result;
  logic               alu_to_mem;
  logic [DATA_W-1:0]  operand_byte;

  // asynchronous read so the instruction completes in its own cycle
  assign operand_byte = data_mem[instr_in.addr];

  aalo_alu u_alu (
    .op_in         (instr_in.op),
    .acc_in        (accumulator_reg),
    .mem_in        (operand_byte),
    .imm_in        (instr_in.imm),
    .flags_in      (flags_reg),
    .flags_out     (alu_flags),
    .result_out    (alu_result),
    .to_memory_out (alu_to_mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel state

  aalo_bus_e          wr_state_reg;
  aalo_bus_e          wr_state_next;
  logic               aw_have_reg;
  logic               aw_have_next;
  logic [AXI_AW-1:0]  awaddr_reg;
  logic [AXI_AW-1:0]  awaddr_next;
  logic               w_have_reg;
  logic               w_have_next;
  logic [DATA_W-1:0]  wdata_reg;
  logic [DATA_W-1:0]  wdata_next;
  logic               wstrb0_reg;
  logic               wstrb0_next;
  logic [1:0]         bresp_reg;
  logic [1:0]         bresp_next;
  logic               wr_go;
  aalo_sel_e          wr_sel;

  // a register write waits while the decoder issues, so instructions never lose a cycle
  assign wr_go  = aw_have_reg && w_have_reg && (wr_state_reg == BUS_IDLE) && !instr_in.valid;
  assign wr_sel = aalo_decode(awaddr_reg);

  assign s_axi_awready_out = !aw_have_reg && (wr_state_reg == BUS_IDLE);
  assign s_axi_wready_out  = !w_have_reg && (wr_state_reg == BUS_IDLE);
  assign s_axi_bvalid_out  = (wr_state_reg == BUS_RESP);
  assign s_axi_bresp_out   = bresp_reg;

  // address and data are captured in either order, the response follows both
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next  = aw_have_reg;
    awaddr_next   = awaddr_reg;
    w_have_next   = w_have_reg;
    wdata_next    = wdata_reg;
    wstrb0_next   = wstrb0_reg;
    bresp_next    = bresp_reg;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata_in[DATA_W-1:0];
      wstrb0_next = s_axi_wstrb_in[0];
    end
    case (wr_state_reg)
      BUS_IDLE: begin
        if (wr_go) begin
          aw_have_next  = 1'b0;
          w_have_next   = 1'b0;
          bresp_next    = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          wr_state_next = BUS_RESP;
        end
      end
      BUS_RESP: begin
        if (s_axi_bready_in) begin
          wr_state_next = BUS_IDLE;
        end
      end
      default: begin
        wr_state_next = BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel state

  aalo_bus_e          rd_state_reg;
  aalo_bus_e          rd_state_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic [1:0]         rresp_reg;
  logic [1:0]         rresp_next;
  aalo_sel_e          rd_sel;

  assign rd_sel            = aalo_decode(s_axi_araddr_in);
  assign s_axi_arready_out = (rd_state_reg == BUS_IDLE);
  assign s_axi_rvalid_out  = (rd_state_reg == BUS_RESP);
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;

  // read data is sampled when the address is taken; unused upper bits read zero
  always_comb begin
    rd_state_next = rd_state_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    case (rd_state_reg)
      BUS_IDLE: begin
        if (s_axi_arvalid_in) begin
          rresp_next    = RESP_OKAY;
          rd_state_next = BUS_RESP;
          if (rd_sel == SEL_ACC) begin
            rdata_next = {24'h000000, accumulator_reg};
          end else if (rd_sel == SEL_FLAGS) begin
            rdata_next = {27'h0000000, flags_reg};
          end else if (rd_sel == SEL_MEM_ADDR) begin
            rdata_next = {24'h000000, mem_addr_reg};
          end else if (rd_sel == SEL_MEM_DATA) begin
            rdata_next = {24'h000000, data_mem[mem_addr_reg]};
          end else begin
            rdata_next = 32'h00000000;
            rresp_next = RESP_SLVERR;
          end
        end
      end
      BUS_RESP: begin
        if (s_axi_rready_in) begin
          rd_state_next = BUS_IDLE;
        end
      end
      default: begin
        rd_state_next = BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction execution and register writes

  // an instruction and a bus write never land in the same cycle, see wr_go
  always_comb begin
    accumulator_next = accumulator_reg;
    flags_next       = flags_reg;
    mem_addr_next    = mem_addr_reg;
    done_next        = 1'b0;
    result_next      = result_reg;
    mem_we           = 1'b0;
    mem_wa           = instr_in.addr;
    mem_wd           = alu_result;
    if (instr_in.valid) begin
      done_next   = 1'b1;
      result_next = alu_result;
      flags_next  = alu_flags;
      if (alu_to_mem) begin
        mem_we = 1'b1;
      end else begin
        accumulator_next = alu_result;
      end
    end else if (wr_go && wstrb0_reg) begin
      if (wr_sel == SEL_ACC) begin
        accumulator_next = wdata_reg;
      end else if (wr_sel == SEL_FLAGS) begin
        flags_next = wdata_reg[FLAG_W-1:0];
      end else if (wr_sel == SEL_MEM_ADDR) begin
        mem_addr_next = wdata_reg;
      end else if (wr_sel == SEL_MEM_DATA) begin
        mem_we = 1'b1;
        mem_wa = mem_addr_reg;
        mem_wd = wdata_reg;
      end
    end
  end

  assign done_out   = done_reg;
  assign result_out = result_reg;
  assign acc_out    = accumulator_reg;
  assign flags_out  = flags_reg;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // memory content has no reset; software loads it before use
  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      data_mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      accumulator_reg <= ACC_RST;
      flags_reg       <= FLAGS_RST;
      mem_addr_reg    <= MEM_ADDR_RST;
      done_reg        <= 1'b0;
      result_reg      <= 8'h00;
      wr_state_reg    <= BUS_IDLE;
      aw_have_reg     <= 1'b0;
      awaddr_reg      <= 8'h00;
      w_have_reg      <= 1'b0;
      wdata_reg       <= 8'h00;
      wstrb0_reg      <= 1'b0;
      bresp_reg       <= RESP_OKAY;
      rd_state_reg    <= BUS_IDLE;
      rdata_reg       <= 32'h00000000;
      rresp_reg       <= RESP_OKAY;
    end else begin
      accumulator_reg <= accumulator_next;
      flags_reg       <= flags_next;
      mem_addr_reg    <= mem_addr_next;
      done_reg        <= done_next;
      result_reg      <= result_next;
      wr_state_reg    <= wr_state_next;
      aw_have_reg     <= aw_have_next;
      awaddr_reg      <= awaddr_next;
      w_have_reg      <= w_have_next;
      wdata_reg       <= wdata_next;
      wstrb0_reg      <= wstrb0_next;
      bresp_reg       <= bresp_next;
      rd_state_reg    <= rd_state_next;
      rdata_reg       <= rdata_next;
      rresp_reg       <= rresp_next;
    end
  end

endmodule : aalo_datapath

/* File: design/aalo_pkg.sv */
// shared constants, types and helpers for the accumulator add and logic datapath
package aalo_pkg;

  localparam int          DATA_W        = 8;
  localparam int          AXI_AW        = 8;
  localparam int          MEM_AW        = 8;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0]  OFF_ACC       = 8'h00;
  localparam logic [7:0]  OFF_FLAGS     = 8'h04;
  localparam logic [7:0]  OFF_MEM_ADDR  = 8'h08;
  localparam logic [7:0]  OFF_MEM_DATA  = 8'h0C;

  // flag bit positions in the flags register
  localparam int          FLAG_C_POS    = 0;
  localparam int          FLAG_AC_POS   = 1;
  localparam int          FLAG_Z_POS    = 2;
  localparam int          FLAG_OV_POS   = 3;
  localparam int          FLAG_SC_POS   = 4;
  localparam int          FLAG_W        = 5;

  // reset values
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [4:0]  FLAGS_RST     = 5'h00;
  localparam logic [7:0]  MEM_ADDR_RST  = 8'h00;

  // bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // instruction codes from the decoder
  typedef enum logic [1:0] {
    OP_ADD_ACC_INTO_MEMORY        = 2'h0,
    OP_AND_MEM_INTO_ACC           = 2'h1,
    OP_AND_IMM_INTO_ACC           = 2'h2,
    OP_BITWISE_CONJ_ACC_INTO_MEM  = 2'h3
  } aalo_op_e;

  // register select produced by the address decoder
  typedef enum logic [3:0] {
    SEL_ACC      = 4'h1,
    SEL_FLAGS    = 4'h2,
    SEL_MEM_ADDR = 4'h4,
    SEL_MEM_DATA = 4'h8,
    SEL_NONE     = 4'h0
  } aalo_sel_e;

  // instruction handed over by the decoder, one cycle per valid
  typedef struct packed {
    logic               valid;
    aalo_op_e           op;
    logic [MEM_AW-1:0]  addr;
    logic [DATA_W-1:0]  imm;
  } aalo_instr_s;

  // status flags as a bundle
  typedef struct packed {
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } aalo_flags_s;

  // true when an eight-bit result is all zeros
  function automatic logic aalo_is_zero(input logic [DATA_W-1:0] value);
    aalo_is_zero = (value == 8'h00);
  endfunction : aalo_is_zero

  // maps a byte address onto one register select
  function automatic aalo_sel_e aalo_decode(input logic [AXI_AW-1:0] addr);
    if (addr == OFF_ACC) begin
      aalo_decode = SEL_ACC;
    end else if (addr == OFF_FLAGS) begin
      aalo_decode = SEL_FLAGS;
    end else if (addr == OFF_MEM_ADDR) begin
      aalo_decode = SEL_MEM_ADDR;
    end else if (addr == OFF_MEM_DATA) begin
      aalo_decode = SEL_MEM_DATA;
    end else begin
      aalo_decode = SEL_NONE;
    end
  endfunction : aalo_decode

endpackage : aalo_pkg

/* File: tb/aalo_datapath_chk.sv */
// checker watching the accumulator datapath top ports
`timescale 1ns/1ns
module aalo_datapath_chk
  import aalo_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  input  wire aalo_instr_s        instr_in,
  input  wire logic               done_out,
  input  wire logic [DATA_W-1:0]  result_out,
  input  wire logic [DATA_W-1:0]  acc_out,
  input  wire aalo_flags_s        flags_out,
  input  wire logic               s_axi_arvalid_in,
  input  wire logic               s_axi_arready_out,
  input  wire logic               s_axi_rvalid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // opcode shorthands, only meaningful while the decoder presents valid
  logic is_add;
  logic is_and_mem;
  logic is_and_imm;
  logic is_conj;
  assign is_add     = instr_in.valid && instr_in.op == OP_ADD_ACC_INTO_MEMORY;
  assign is_and_mem = instr_in.valid && instr_in.op == OP_AND_MEM_INTO_ACC;
  assign is_and_imm = instr_in.valid && instr_in.op == OP_AND_IMM_INTO_ACC;
  assign is_conj    = instr_in.valid && instr_in.op == OP_BITWISE_CONJ_ACC_INTO_MEM;

  //////////////////////////////////////////////////////////////////////////////
  // done follows every taken instruction by exactly one cycle
  a_done_pulse:
    assert property (!$past(rst_in) |-> done_out == $past(instr_in.valid)) else $error("done pulse mismatch");
  a_add_acc_kept:
    assert property (is_add |=> $stable(acc_out)) else $error("add changed the accumulator");
  // a wrapped sum is below the old accumulator exactly when carry is out
  a_add_carry:
    assert property (is_add |=> flags_out.carry_flag == (result_out < $past(acc_out))) else $error("carry wrong");
  a_add_signed:
    assert property (is_add |=> flags_out.signed_compare_flag == (flags_out.overflow_flag ^ result_out[7]))
      else $error("signed compare wrong");
  a_and_flags_kept:
    assert property (instr_in.valid && !is_add |=> $stable(flags_out.carry_flag) && $stable(flags_out.aux_carry_flag)
      && $stable(flags_out.overflow_flag) && $stable(flags_out.signed_compare_flag)) else $error("and touched flags");
  a_zero_flag:
    assert property (instr_in.valid |=> flags_out.zero_flag == (result_out == 8'h00)) else $error("zero flag wrong");
  a_imm_result:
    assert property (is_and_imm |=> acc_out == ($past(acc_out) & $past(instr_in.imm)) && result_out == acc_out)
      else $error("immediate and wrong");
  a_mem_and_acc:
    assert property (is_and_mem |=> acc_out == result_out && (result_out & ~$past(acc_out)) == 8'h00)
      else $error("memory and wrong");
  a_conj_mem:
    assert property (is_conj |=> $stable(acc_out) && (result_out & ~acc_out) == 8'h00) else $error("and to memory wrong");
  a_read_answer:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read answer late");
endmodule : aalo_datapath_chk

bind aalo_datapath aalo_datapath_chk u_chk (.clk_sys_in, .rst_in, .instr_in, .done_out, .result_out, .acc_out,
  .flags_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out);

/* File: tb/accumulator_add_and_logic_ops_tb_top.sv */
// self-checking bench: register bus access and instruction sequences
`timescale 1ns/1ns
module accumulator_add_and_logic_ops_tb_top;
  import aalo_pkg::*;
  logic              clk_sys_in;
  logic              rst_in;
  aalo_instr_s       instr_in;
  logic              done_out;
  logic [7:0]        result_out;
  logic [7:0]        acc_out;
  aalo_flags_s       flags_out;
  logic [7:0]        s_axi_awaddr_in;
  logic              s_axi_awvalid_in;
  logic              s_axi_awready_out;
  logic [31:0]       s_axi_wdata_in;
  logic [3:0]        s_axi_wstrb_in;
  logic              s_axi_wvalid_in;
  logic              s_axi_wready_out;
  logic [1:0]        s_axi_bresp_out;
  logic              s_axi_bvalid_out;
  logic              s_axi_bready_in;
  logic [7:0]        s_axi_araddr_in;
  logic              s_axi_arvalid_in;
  logic              s_axi_arready_out;
  logic [31:0]       s_axi_rdata_out;
  logic [1:0]        s_axi_rresp_out;
  logic              s_axi_rvalid_out;
  logic              s_axi_rready_in;
  int                n_errors = 0;
  int                compares = 0;
  logic [7:0]        va [4] = '{8'h7F, 8'hFF, 8'h80, 8'h0F};
  logic [7:0]        vm [4] = '{8'h01, 8'h01, 8'h80, 8'h01};

  // 25 MHz clock
  initial begin
    clk_sys_in = 1'h0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  aalo_datapath uut (.clk_sys_in, .rst_in, .instr_in, .done_out, .result_out, .acc_out, .flags_out,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);

  //////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task close_out;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////
  // bus master; bready rides with the request so the answer is taken on its first edge
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wdata_in <= d;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_bvalid_out) break;
    end
    s_axi_bready_in <= 1'h0;
    if (n == 64) begin
      n_errors++;
      close_out();
    end
    check("bresp", {30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      if (s_axi_rvalid_out) break;
    end
    s_axi_rready_in <= 1'h0;
    if (n == 64) begin
      n_errors++;
      close_out();
    end
    d = s_axi_rdata_out;
    check("rresp", {30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask : axi_rd

  // memory goes through the pointer register, no auto-increment
  task set_mem(input logic [7:0] a, input logic [7:0] d);
    axi_wr(OFF_MEM_ADDR, {24'h0, a}, RESP_OKAY);
    axi_wr(OFF_MEM_DATA, {24'h0, d}, RESP_OKAY);
  endtask : set_mem

  task mem_is(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    axi_wr(OFF_MEM_ADDR, {24'h0, a}, RESP_OKAY);
    axi_rd(OFF_MEM_DATA, v, RESP_OKAY);
    check("mem", v, {24'h0, e});
  endtask : mem_is

  // one instruction, valid for a single cycle
  task do_op(input aalo_op_e op, input logic [7:0] a, input logic [7:0] imm);
    @(posedge clk_sys_in);
    instr_in <= {1'h1, op, a, imm};
    @(posedge clk_sys_in);
    instr_in.valid <= 1'h0;
    #1;
    check("done", {31'h0, done_out}, 32'h1);
  endtask : do_op

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] v;
    logic [8:0]  s;
    logic        ov;
    logic        ac;
    instr_in = '0;
    {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'hF;
    rst_in = 1'h1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    axi_rd(OFF_ACC, v, RESP_OKAY);
    check("acc reg", v, 32'h0);
    axi_rd(OFF_FLAGS, v, RESP_OKAY);
    check("flags reg", v, 32'h0);
    axi_rd(8'h10, v, RESP_SLVERR);
    check("unmapped", v, 32'h0);
    axi_wr(8'h14, 32'h55, RESP_SLVERR);
    axi_rd(OFF_MEM_ADDR, v, RESP_OKAY);
    check("ptr reg", v, 32'h0);
    // a write with byte lane 0 off is answered but must not land
    s_axi_wstrb_in <= 4'h0;
    axi_wr(OFF_ACC, 32'hA5, RESP_OKAY);
    s_axi_wstrb_in <= 4'hF;
    axi_rd(OFF_ACC, v, RESP_OKAY);
    check("strb off", v, 32'h0);
    $display("test reset and map done");
    // add over carry, overflow and half-carry corners; expectations from bit arithmetic
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFF_ACC, {24'h0, va[i]}, RESP_OKAY);
      set_mem(8'h40 + i[7:0], vm[i]);
      do_op(OP_ADD_ACC_INTO_MEMORY, 8'h40 + i[7:0], 8'h00);
      s = {1'h0, va[i]} + {1'h0, vm[i]};
      ac = ({1'h0, va[i][3:0]} + {1'h0, vm[i][3:0]}) > 5'h0F;
      ov = (va[i][7] == vm[i][7]) && (s[7] != va[i][7]);
      check("sum", {24'h0, result_out}, {24'h0, s[7:0]});
      check("acc kept", {24'h0, acc_out}, {24'h0, va[i]});
      check("add flags", {27'h0, flags_out}, {27'h0, ov ^ s[7], ov, s[7:0] == 8'h00, ac, s[8]});
      mem_is(8'h40 + i[7:0], s[7:0]);
    end
    $display("test add done");
    // and forms: the non-zero flags are preset so any stray change shows
    axi_wr(OFF_FLAGS, 32'h1B, RESP_OKAY);
    axi_wr(OFF_ACC, 32'hF0, RESP_OKAY);
    set_mem(8'h21, 8'h0F);
    do_op(OP_AND_MEM_INTO_ACC, 8'h21, 8'hFF);
    check("and mem acc", {24'h0, acc_out}, 32'h0);
    check("and mem flags", {27'h0, flags_out}, 32'h1F);
    mem_is(8'h21, 8'h0F);
    axi_wr(OFF_ACC, 32'h3C, RESP_OKAY);
    do_op(OP_AND_IMM_INTO_ACC, 8'h21, 8'hF5);
    check("and imm acc", {24'h0, acc_out}, 32'h34);
    check("and imm flags", {27'h0, flags_out}, 32'h1B);
    mem_is(8'h21, 8'h0F);
    set_mem(8'h22, 8'h1C);
    do_op(OP_BITWISE_CONJ_ACC_INTO_MEM, 8'h22, 8'h00);
    check("conj acc", {24'h0, acc_out}, 32'h34);
    mem_is(8'h22, 8'h14);
    axi_wr(OFF_ACC, 32'h03, RESP_OKAY);
    do_op(OP_BITWISE_CONJ_ACC_INTO_MEM, 8'h22, 8'h00);
    check("conj zero", {27'h0, flags_out}, 32'h1F);
    mem_is(8'h22, 8'h00);
    $display("test and forms done");
    // back to back: the and must see the memory byte the add just wrote
    axi_wr(OFF_ACC, 32'h01, RESP_OKAY);
    set_mem(8'h30, 8'hFF);
    @(posedge clk_sys_in);
    instr_in <= {1'h1, OP_ADD_ACC_INTO_MEMORY, 8'h30, 8'h00};
    @(posedge clk_sys_in);
    instr_in <= {1'h1, OP_AND_MEM_INTO_ACC, 8'h30, 8'h00};
    @(posedge clk_sys_in);
    instr_in.valid <= 1'h0;
    #1;
    check("b2b acc", {24'h0, acc_out}, 32'h0);
    check("b2b flags", {27'h0, flags_out}, 32'h07);
    $display("test back to back done");
    close_out();
  end
endmodule : accumulator_add_and_logic_ops_tb_top
